// >>> src/rle_decoder_map.svh
`ifndef RLE_DECODER_MAP_SVH
`define RLE_DECODER_MAP_SVH

// compression field values carried in the image header
`define CMP_NONE 2'h0
`define CMP_BASIC 2'h1
`define CMP_ENH 2'h2

// control byte values
`define CTL_ZERO 8'h00
`define CTL_ONE 8'h01

// long lengths: top bit flags a second byte, low seven bits hold the low part
`define LEN_LONG_BIT 7
`define LEN_LOW_MASK 8'h7F

// line buffer geometry: pixels held per line and index width
`define LINE_DEPTH 256
`define LINE_IDX_W 8

// byte alignment of padding: low bits of the byte count that must be zero
`define ALIGN_W 2

// byte source select values
`define SRC_FLASH 1'h0
`define SRC_DOWNLOAD 1'h1

`endif

// >>> src/rle_decoder_pkg.sv
package rle_decoder_pkg;

  // decoder sequencing states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTL1,
    ST_CTL2,
    ST_CTL3,
    ST_LEN_HI,
    ST_PIXB,
    ST_EMIT,
    ST_PAD
  } state_t;

  // what the current run does with its pixels
  typedef enum logic [1:0] {
    OP_REP,
    OP_LIT,
    OP_COPY,
    OP_RAW
  } op_t;

endpackage

// >>> src/line_buffer.sv
`include "rle_decoder_map.svh"

module line_buffer (
  // clock
  input wire logic ref_clk_in,
  // write side
  input wire logic wr_en_in,
  input wire logic [`LINE_IDX_W-1:0] wr_idx_in,
  input wire logic [23:0] wr_data_in,
  // read side
  input wire logic [`LINE_IDX_W-1:0] rd_idx_in,
  output logic [23:0] rd_data_out
);

  logic [23:0] mem_ff [`LINE_DEPTH];

  // read is combinational so the old pixel at a column is seen before it is overwritten
  assign rd_data_out = mem_ff[rd_idx_in];

  // one pixel per write
  always_ff @(posedge ref_clk_in)
  begin
    if (wr_en_in)
    begin
      mem_ff[wr_idx_in] <= wr_data_in;
    end
  end

endmodule

// >>> src/pixel_gather.sv
module pixel_gather (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // byte side
  input wire logic clr_in,
  input wire logic load_in,
  input wire logic [7:0] byte_in,
  // assembled pixel
  output logic [23:0] pixel_out,
  output logic third_out
);

  logic [1:0] cnt_ff;
  logic [15:0] hold_ff;
  logic [1:0] nxt_cnt;
  logic [15:0] nxt_hold;

  // first stored byte lands in the top bits
  assign third_out = load_in && (cnt_ff == 2'h2);
  assign pixel_out = {hold_ff, byte_in};
  assign nxt_cnt = (clr_in || third_out) ? 2'h0 : (load_in ? cnt_ff + 2'h1 : cnt_ff);
  assign nxt_hold = load_in ? {hold_ff[7:0], byte_in} : hold_ff;

  // byte counter and holding register
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt_ff <= 2'h0;
      hold_ff <= 16'h0000;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      hold_ff <= nxt_hold;
    end
  end

endmodule

// >>> src/pattern_image_rle_decoder.sv
// Functional notes
// - the compression field picks the mode: 0 pass-through, 1 basic run-length, 2 enhanced.
// - an uncompressed image is forwarded to image memory byte for byte with no expansion.
// - decoding runs on the fly from the flash byte source or from the download source.
// - every pixel is 24-bit RGB built from three consecutive stored bytes.
// - lines come out in stored order, the first stored line being the top line.
// - in basic mode a nonzero first control byte n repeats the following pixel n times.
// - in basic mode zero then a count c of two or more copies the next c pixels literally.
// - in enhanced mode a leading length n repeats the following pixel n times.
// - in enhanced mode zero then a length n passes the next n pixels through literally.
// - in enhanced mode zero,one,n copies n pixels from the same columns of the line above, for widths up to 256.
// - in enhanced mode a length below 128 is one byte.
// - in enhanced mode a length of 128 or more is two bytes, low seven bits with top bit set, then n shifted by 7.
// - enhanced streams decode correctly with or without end-of-line codes, which skip no padding; only the end of image is padded.
`include "rle_decoder_map.svh"

module pattern_image_rle_decoder (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // image control
  input wire logic start_in,
  input wire logic [1:0] mode_in,
  input wire logic src_sel_in,
  input wire logic [15:0] width_in,
  input wire logic [15:0] height_in,
  output logic busy_out,
  output logic done_out,
  // flash byte source
  input wire logic [7:0] flash_data_in,
  input wire logic flash_valid_in,
  output logic flash_ready_out,
  // download byte source
  input wire logic [7:0] dl_data_in,
  input wire logic dl_valid_in,
  output logic dl_ready_out,
  // pixel stream to pattern memory
  output logic [23:0] pix_data_out,
  output logic [15:0] pix_x_out,
  output logic [15:0] pix_y_out,
  output logic pix_eol_out,
  output logic pix_valid_out,
  input wire logic pix_ready_in
);

  rle_decoder_pkg::state_t state_ff, nxt_state;
  rle_decoder_pkg::op_t op_ff, nxt_op;
  rle_decoder_pkg::op_t pend_ff, nxt_pend;
  logic enh_ff, nxt_enh;
  logic sel_ff, nxt_sel;
  logic [15:0] width_ff, nxt_width;
  logic [15:0] height_ff, nxt_height;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [6:0] lo_ff, nxt_lo;
  logic [23:0] pix_ff, nxt_pix;
  logic [15:0] x_ff, nxt_x;
  logic [15:0] y_ff, nxt_y;
  logic [`ALIGN_W-1:0] bcnt_ff, nxt_bcnt;
  logic eoi_ff, nxt_eoi;
  logic rdy_ff, nxt_rdy;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic [23:0] pdata_ff, nxt_pdata;
  logic [15:0] px_ff, nxt_px;
  logic [15:0] py_ff, nxt_py;
  logic peol_ff, nxt_peol;
  logic pv_ff, nxt_pv;

  // a length byte with the top bit set announces a second byte, enhanced mode only
  function automatic logic is_long(input logic [7:0] b, input logic enh);
    is_long = enh && b[`LEN_LONG_BIT];
  endfunction

  // state wanting a byte in the coming cycle
  function automatic logic wants_byte(input rle_decoder_pkg::state_t st,
                                      input logic [`ALIGN_W-1:0] bc);
    case (st)
      rle_decoder_pkg::ST_CTL1,
      rle_decoder_pkg::ST_CTL2,
      rle_decoder_pkg::ST_CTL3,
      rle_decoder_pkg::ST_LEN_HI,
      rle_decoder_pkg::ST_PIXB: wants_byte = 1'b1;
      rle_decoder_pkg::ST_PAD: wants_byte = (bc != '0);
      default: wants_byte = 1'b0;
    endcase
  endfunction

  // source selection and byte handshake
  wire [7:0] src_byte = (sel_ff == `SRC_DOWNLOAD) ? dl_data_in : flash_data_in;
  wire src_valid = (sel_ff == `SRC_DOWNLOAD) ? dl_valid_in : flash_valid_in;
  wire take = rdy_ff && src_valid;
  wire byte_zero = (src_byte == `CTL_ZERO);
  wire byte_one = (src_byte == `CTL_ONE);
  wire [15:0] len_short = {8'h00, src_byte};
  wire [15:0] len_long = {1'b0, src_byte, lo_ff};

  // pixel output side and line position
  wire out_free = !pv_ff || pix_ready_in;
  wire emit = (state_ff == rle_decoder_pkg::ST_EMIT) && out_free;
  wire x_last = (x_ff == width_ff - 16'h0001);
  wire y_last = (y_ff == height_ff - 16'h0001);
  wire run_last = (cnt_ff <= 16'h0001);
  wire [23:0] prev_pix;
  wire [23:0] emit_pix = (op_ff == rle_decoder_pkg::OP_COPY) ? prev_pix : pix_ff;
  wire gather_load = take && (state_ff == rle_decoder_pkg::ST_PIXB);
  wire gather_clr = (state_ff == rle_decoder_pkg::ST_IDLE);
  wire [23:0] gathered;
  wire gathered_full;

  // three stored bytes make one pixel
  pixel_gather u_gather (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .clr_in(gather_clr),
    .load_in(gather_load),
    .byte_in(src_byte),
    .pixel_out(gathered),
    .third_out(gathered_full)
  );

  // previous line for copy runs; written at the same column it is read from
  line_buffer u_line (
    .ref_clk_in(ref_clk_in),
    .wr_en_in(emit),
    .wr_idx_in(x_ff[`LINE_IDX_W-1:0]),
    .wr_data_in(emit_pix),
    .rd_idx_in(x_ff[`LINE_IDX_W-1:0]),
    .rd_data_out(prev_pix)
  );

  // control byte decoding and run sequencing
  always_comb
  begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_pend = pend_ff;
    nxt_enh = enh_ff;
    nxt_sel = sel_ff;
    nxt_width = width_ff;
    nxt_height = height_ff;
    nxt_cnt = cnt_ff;
    nxt_lo = lo_ff;
    nxt_pix = pix_ff;
    nxt_x = x_ff;
    nxt_y = y_ff;
    nxt_bcnt = take ? bcnt_ff + 2'h1 : bcnt_ff;
    nxt_eoi = eoi_ff;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_pdata = pdata_ff;
    nxt_px = px_ff;
    nxt_py = py_ff;
    nxt_peol = peol_ff;
    nxt_pv = pix_ready_in ? 1'b0 : pv_ff;
    case (state_ff)
      rle_decoder_pkg::ST_IDLE:
      begin
        if (start_in)
        begin
          nxt_sel = src_sel_in;
          nxt_enh = (mode_in == `CMP_ENH);
          nxt_width = width_in;
          nxt_height = height_in;
          nxt_x = 16'h0000;
          nxt_y = 16'h0000;
          nxt_bcnt = '0;
          nxt_eoi = 1'b0;
          nxt_busy = 1'b1;
          nxt_op = rle_decoder_pkg::OP_RAW;
          nxt_state = (mode_in == `CMP_NONE) ? rle_decoder_pkg::ST_PIXB
                                             : rle_decoder_pkg::ST_CTL1;
        end
      end
      rle_decoder_pkg::ST_CTL1:
      begin
        if (take)
        begin
          nxt_op = rle_decoder_pkg::OP_REP;
          nxt_cnt = len_short;
          nxt_lo = src_byte[6:0];
          nxt_pend = rle_decoder_pkg::OP_REP;
          if (byte_zero)
            nxt_state = rle_decoder_pkg::ST_CTL2;
          else if (is_long(src_byte, enh_ff))
            nxt_state = rle_decoder_pkg::ST_LEN_HI;
          else
            nxt_state = rle_decoder_pkg::ST_PIXB;
        end
      end
      rle_decoder_pkg::ST_CTL2:
      begin
        if (take)
        begin
          nxt_op = rle_decoder_pkg::OP_LIT;
          nxt_cnt = len_short;
          nxt_lo = src_byte[6:0];
          nxt_pend = rle_decoder_pkg::OP_LIT;
          if (byte_zero)
          begin
            // end of line: a line already closed by width leaves the position alone
            if (x_ff != 16'h0000)
            begin
              nxt_x = 16'h0000;
              nxt_y = y_ff + 16'h0001;
            end
            nxt_state = enh_ff ? rle_decoder_pkg::ST_CTL1 : rle_decoder_pkg::ST_PAD;
          end
          else if (byte_one)
          begin
            nxt_eoi = !enh_ff;
            nxt_state = enh_ff ? rle_decoder_pkg::ST_CTL3 : rle_decoder_pkg::ST_PAD;
          end
          else if (is_long(src_byte, enh_ff))
            nxt_state = rle_decoder_pkg::ST_LEN_HI;
          else
            nxt_state = rle_decoder_pkg::ST_PIXB;
        end
      end
      rle_decoder_pkg::ST_CTL3:
      begin
        if (take)
        begin
          nxt_op = rle_decoder_pkg::OP_COPY;
          nxt_cnt = len_short;
          nxt_lo = src_byte[6:0];
          nxt_pend = rle_decoder_pkg::OP_COPY;
          if (byte_zero)
          begin
            nxt_eoi = 1'b1;
            nxt_state = rle_decoder_pkg::ST_PAD;
          end
          else if (is_long(src_byte, enh_ff))
            nxt_state = rle_decoder_pkg::ST_LEN_HI;
          else
            nxt_state = rle_decoder_pkg::ST_EMIT;
        end
      end
      rle_decoder_pkg::ST_LEN_HI:
      begin
        if (take)
        begin
          nxt_cnt = len_long;
          nxt_op = pend_ff;
          nxt_state = (pend_ff == rle_decoder_pkg::OP_COPY) ? rle_decoder_pkg::ST_EMIT
                                                            : rle_decoder_pkg::ST_PIXB;
        end
      end
      rle_decoder_pkg::ST_PIXB:
      begin
        if (gathered_full)
        begin
          nxt_pix = gathered;
          nxt_state = rle_decoder_pkg::ST_EMIT;
        end
      end
      rle_decoder_pkg::ST_EMIT:
      begin
        if (emit)
        begin
          nxt_pdata = emit_pix;
          nxt_px = x_ff;
          nxt_py = y_ff;
          nxt_peol = x_last;
          nxt_pv = 1'b1;
          nxt_x = x_last ? 16'h0000 : x_ff + 16'h0001;
          nxt_y = x_last ? y_ff + 16'h0001 : y_ff;
          nxt_cnt = cnt_ff - 16'h0001;
          case (op_ff)
            rle_decoder_pkg::OP_RAW:
            begin
              // pass-through ends on the last pixel of the declared size
              if (x_last && y_last)
              begin
                nxt_busy = 1'b0;
                nxt_done = 1'b1;
                nxt_state = rle_decoder_pkg::ST_IDLE;
              end
              else
                nxt_state = rle_decoder_pkg::ST_PIXB;
            end
            rle_decoder_pkg::OP_LIT:
              nxt_state = run_last ? rle_decoder_pkg::ST_CTL1
                                   : rle_decoder_pkg::ST_PIXB;
            default:
              nxt_state = run_last ? rle_decoder_pkg::ST_CTL1
                                   : rle_decoder_pkg::ST_EMIT;
          endcase
        end
      end
      rle_decoder_pkg::ST_PAD:
      begin
        // skip padding up to the next four-byte boundary
        if (nxt_bcnt == '0)
        begin
          if (eoi_ff)
          begin
            nxt_busy = 1'b0;
            nxt_done = 1'b1;
            nxt_state = rle_decoder_pkg::ST_IDLE;
          end
          else
            nxt_state = rle_decoder_pkg::ST_CTL1;
        end
      end
      default:
        nxt_state = rle_decoder_pkg::ST_IDLE;
    endcase
    nxt_rdy = wants_byte(nxt_state, nxt_bcnt);
  end

  // ready is registered and follows the state being entered
  assign flash_ready_out = rdy_ff && (sel_ff == `SRC_FLASH);
  assign dl_ready_out = rdy_ff && (sel_ff == `SRC_DOWNLOAD);
  assign busy_out = busy_ff;
  assign done_out = done_ff;
  assign pix_data_out = pdata_ff;
  assign pix_x_out = px_ff;
  assign pix_y_out = py_ff;
  assign pix_eol_out = peol_ff;
  assign pix_valid_out = pv_ff;

  // sequencer state
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_ff <= rle_decoder_pkg::ST_IDLE;
      op_ff <= rle_decoder_pkg::OP_RAW;
      pend_ff <= rle_decoder_pkg::OP_REP;
      enh_ff <= 1'b0;
      sel_ff <= `SRC_FLASH;
      width_ff <= 16'h0000;
      height_ff <= 16'h0000;
      cnt_ff <= 16'h0000;
      lo_ff <= 7'h00;
      pix_ff <= 24'h000000;
      x_ff <= 16'h0000;
      y_ff <= 16'h0000;
      bcnt_ff <= '0;
      eoi_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      pend_ff <= nxt_pend;
      enh_ff <= nxt_enh;
      sel_ff <= nxt_sel;
      width_ff <= nxt_width;
      height_ff <= nxt_height;
      cnt_ff <= nxt_cnt;
      lo_ff <= nxt_lo;
      pix_ff <= nxt_pix;
      x_ff <= nxt_x;
      y_ff <= nxt_y;
      bcnt_ff <= nxt_bcnt;
      eoi_ff <= nxt_eoi;
    end
  end

  // output registers
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      rdy_ff <= 1'b0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      pdata_ff <= 24'h000000;
      px_ff <= 16'h0000;
      py_ff <= 16'h0000;
      peol_ff <= 1'b0;
      pv_ff <= 1'b0;
    end
    else
    begin
      rdy_ff <= nxt_rdy;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      pdata_ff <= nxt_pdata;
      px_ff <= nxt_px;
      py_ff <= nxt_py;
      peol_ff <= nxt_peol;
      pv_ff <= nxt_pv;
    end
  end

endmodule

// >>> bench/rle_decoder_checker.sv
module rle_decoder_checker (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // control
  input wire logic start_in,
  input wire logic src_sel_in,
  input wire logic [15:0] width_in,
  input wire logic busy_out,
  input wire logic done_out,
  // byte sources
  input wire logic flash_ready_out,
  input wire logic dl_ready_out,
  // pixel side
  input wire logic [23:0] pix_data_out,
  input wire logic [15:0] pix_x_out,
  input wire logic pix_eol_out,
  input wire logic pix_valid_out,
  input wire logic pix_ready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] w_ff;
  logic src_ff;
  // width and source as taken at start
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      w_ff <= 16'h0000;
      src_ff <= 1'h0;
    end
    else if (start_in && !busy_out)
    begin
      w_ff <= width_in;
      src_ff <= src_sel_in;
    end
  end
  // every check runs on the one clock
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!reset_n_in);
  a_start_busy: assert property (start_in && !busy_out |=> busy_out)
    else $error("no busy after start");
  a_flash_sel: assert property (flash_ready_out |-> busy_out && !src_ff)
    else $error("flash ready while not selected");
  a_dl_sel: assert property (dl_ready_out |-> busy_out && src_ff)
    else $error("download ready while not selected");
  a_pix_hold: assert property (pix_valid_out && !pix_ready_in |=>
    pix_valid_out && $stable({pix_data_out, pix_x_out, pix_eol_out}))
    else $error("pixel changed before taken");
  a_eol_col: assert property (pix_valid_out |->
    pix_eol_out == (pix_x_out == w_ff - 16'h0001))
    else $error("line end flag wrong");
  a_x_range: assert property (pix_valid_out |-> pix_x_out < w_ff)
    else $error("column beyond width");
  a_done_once: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  a_done_end: assert property (done_out |-> !busy_out && $past(busy_out))
    else $error("done without busy falling");
  a_busy_fall: assert property ($fell(busy_out) |-> done_out)
    else $error("busy fell without done");
  c_done: cover property (done_out);
  c_stall: cover property (pix_valid_out && !pix_ready_in);
  c_dl: cover property (dl_ready_out);
endmodule

bind pattern_image_rle_decoder rle_decoder_checker chk (.ref_clk_in(ref_clk_in),
  .reset_n_in(reset_n_in), .start_in(start_in), .src_sel_in(src_sel_in),
  .width_in(width_in), .busy_out(busy_out), .done_out(done_out),
  .flash_ready_out(flash_ready_out), .dl_ready_out(dl_ready_out),
  .pix_data_out(pix_data_out), .pix_x_out(pix_x_out), .pix_eol_out(pix_eol_out),
  .pix_valid_out(pix_valid_out), .pix_ready_in(pix_ready_in));

// >>> bench/byte_source.sv
module byte_source (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  // pacing
  input wire logic slow_in,
  // byte handshake
  input wire logic ready_in,
  output logic [7:0] data_out,
  output logic valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  int cnt;
  logic took;
  // queue handling, bytes kept in stored order
  task automatic clear();
    q.delete();
    cnt = 0;
  endtask
  task automatic push(input logic [7:0] b);
    q.push_back(b);
    cnt++;
  endtask
  task automatic pad();
    while (cnt % 4 != 0)
      push(8'h00);
  endtask
  // hold a byte until taken; slow pacing gaps after each take; idle data toggles
  always @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      valid_out <= 1'b0;
      data_out <= 8'h00;
    end
    else
    begin
      took = valid_out && ready_in;
      if (took)
        void'(q.pop_front());
      valid_out <= q.size() != 0 && !(slow_in && took);
      data_out <= (q.size() != 0 && !(slow_in && took)) ? q[0] : ~data_out;
    end
  end
endmodule

// >>> bench/pattern_image_rle_decoder_tb.sv
module pattern_image_rle_decoder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic start_in = 1'b0;
  logic [1:0] mode_in = 2'h0;
  logic src_sel_in = 1'b0;
  logic [15:0] width_in = 16'h0001;
  logic [15:0] height_in = 16'h0001;
  logic pix_ready_in = 1'b1;
  logic busy_out, done_out, flash_valid_in, flash_ready_out, dl_valid_in, dl_ready_out;
  logic [7:0] flash_data_in, dl_data_in;
  logic [23:0] pix_data_out;
  logic [15:0] pix_x_out, pix_y_out;
  logic pix_eol_out, pix_valid_out;
  logic slow = 1'b0;
  logic stall = 1'b0;
  logic src;
  logic [56:0] exq[$];
  int w, ex_x, ex_y;
  int cyc = 0;
  int mismatches = 0;
  int comparisons = 0;

  pattern_image_rle_decoder uut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .start_in(start_in), .mode_in(mode_in), .src_sel_in(src_sel_in), .width_in(width_in),
    .height_in(height_in), .busy_out(busy_out), .done_out(done_out),
    .flash_data_in(flash_data_in), .flash_valid_in(flash_valid_in),
    .flash_ready_out(flash_ready_out), .dl_data_in(dl_data_in), .dl_valid_in(dl_valid_in),
    .dl_ready_out(dl_ready_out), .pix_data_out(pix_data_out), .pix_x_out(pix_x_out),
    .pix_y_out(pix_y_out), .pix_eol_out(pix_eol_out), .pix_valid_out(pix_valid_out),
    .pix_ready_in(pix_ready_in));
  byte_source fsrc (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .slow_in(slow),
    .ready_in(flash_ready_out), .data_out(flash_data_in), .valid_out(flash_valid_in));
  byte_source dsrc (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .slow_in(slow),
    .ready_in(dl_ready_out), .data_out(dl_data_in), .valid_out(dl_valid_in));

  // clock
  initial
  begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // sink: always ready, or refusing one cycle in three
  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    pix_ready_in <= !stall || (cyc % 3 != 0);
  end
  // every accepted pixel against the next expected one
  always @(posedge ref_clk_in)
  begin
    if (reset_n_in && pix_valid_out === 1'b1 && pix_ready_in)
    begin
      if (exq.size() == 0)
        check(57'h1, 57'h0, "extra pixel");
      else
        check({pix_eol_out, pix_data_out, pix_x_out, pix_y_out}, exq.pop_front(), "pixel");
    end
  end

  task automatic check(input logic [56:0] seen, input logic [56:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // stream building and expected raster, wrapping at the width
  task automatic put(input logic [7:0] b);
    if (src)
      dsrc.push(b);
    else
      fsrc.push(b);
  endtask
  task automatic pp(input logic [23:0] d);
    put(d[23:16]);
    put(d[15:8]);
    put(d[7:0]);
  endtask
  task automatic ex(input logic [23:0] d, input int n);
    repeat (n)
    begin
      exq.push_back({1'(ex_x == w - 1), d, 16'(ex_x), 16'(ex_y)});
      ex_x = (ex_x == w - 1) ? 0 : ex_x + 1;
      ex_y = (ex_x == 0) ? ex_y + 1 : ex_y;
    end
  endtask
  task automatic lit(input logic [23:0] d);
    pp(d);
    ex(d, 1);
  endtask
  task automatic rep(input logic [7:0] n, input logic [23:0] d);
    put(n);
    pp(d);
    ex(d, int'(n));
  endtask
  task automatic fin(input logic enh);
    put(8'h00);
    put(8'h01);
    if (enh)
      put(8'h00);
    if (src)
      dsrc.pad();
    else
      fsrc.pad();
  endtask
  task automatic prep(input logic s, input int wd, input logic sl, input logic st);
    @(posedge ref_clk_in);
    slow <= sl;
    stall <= st;
    src = s;
    w = wd;
    ex_x = 0;
    ex_y = 0;
    fsrc.clear();
    dsrc.clear();
  endtask
  task automatic run(input logic [1:0] m, input logic [15:0] ht);
    int n;
    start_in <= 1'b1;
    mode_in <= m;
    src_sel_in <= src;
    width_in <= 16'(w);
    height_in <= ht;
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 4000)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    check(57'(n < 4000), 57'h1, "image end");
    // the last pixel may come out with done and wait on a stalled sink
    repeat (3) @(negedge ref_clk_in);
    check(57'(exq.size()), 57'h0, "pixels missing");
    check(57'(fsrc.q.size() + dsrc.q.size()), 57'h0, "bytes left");
  endtask

  // uncompressed 2 x 2 image from the download source
  task automatic t_raw();
    prep(1'b1, 2, 1'b0, 1'b0);
    lit(24'h112233);
    lit(24'h445566);
    lit(24'hAABBCC);
    lit(24'h000001);
    run(2'h0, 16'h0002);
  endtask
  // basic example stream, slow download source, padded end of line
  task automatic t_basic();
    prep(1'b1, 16, 1'b1, 1'b0);
    rep(8'h03, 24'h040506);
    rep(8'h05, 24'h777777);
    put(8'h00);
    put(8'h03);
    lit(24'h040506);
    lit(24'h070809);
    lit(24'h0A0B0C);
    rep(8'h02, 24'h789ABC);
    repeat (5) put(8'h00);
    ex_x = 0;
    ex_y = 1;
    rep(8'h07, 24'h1D1E1F);
    rep(8'h06, 24'h212223);
    fin(1'b0);
    run(2'h1, 16'h0001);
  endtask
  // enhanced stream: long length, empty end of line, copy from the line above
  task automatic t_enh();
    prep(1'b0, 141, 1'b1, 1'b1);
    rep(8'h03, 24'h040506);
    rep(8'h05, 24'h777777);
    put(8'h00);
    put(8'h03);
    lit(24'h040506);
    lit(24'h070809);
    lit(24'h0A0B0C);
    put(8'h82);
    put(8'h01);
    pp(24'h789ABC);
    ex(24'h789ABC, 130);
    put(8'h00);
    put(8'h00);
    rep(8'h01, 24'h010203);
    put(8'h00);
    put(8'h01);
    put(8'h09);
    ex(24'h040506, 2);
    ex(24'h777777, 5);
    ex(24'h040506, 1);
    ex(24'h070809, 1);
    fin(1'b1);
    run(2'h2, 16'h0001);
  endtask
  // length limits 128 and 127, then basic minimum counts from flash
  task automatic t_edge();
    prep(1'b1, 128, 1'b0, 1'b1);
    put(8'h80);
    put(8'h01);
    pp(24'h123456);
    ex(24'h123456, 128);
    rep(8'h7F, 24'h654321);
    put(8'h00);
    put(8'h02);
    lit(24'h0F0E0D);
    lit(24'h0C0B0A);
    fin(1'b1);
    run(2'h2, 16'h0001);
    prep(1'b0, 4, 1'b0, 1'b0);
    rep(8'h01, 24'hFFFFFF);
    put(8'h00);
    put(8'h02);
    lit(24'h0000FF);
    lit(24'hFF0000);
    fin(1'b0);
    run(2'h1, 16'h0001);
  endtask

  // main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    t_raw();
    t_basic();
    t_enh();
    t_edge();
    summarize();
  end
  // watchdog
  initial
  begin
    #400000;
    mismatches++;
    summarize();
  end
endmodule
